/* rtl/aesu_level_change.sv */
// level flags: each bit shows its level, a pending bit marks any change
// assumes levels are synchronous; the pending bits clear on one strobe
module aesu_level_change
    import aesu_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic [W-1:0] i_level,
    input wire logic i_clear,
    output logic [W-1:0] o_state,
    output logic [W-1:0] o_pending
);

    logic [W-1:0] state_reg;
    logic [W-1:0] state_next;
    logic [W-1:0] pend_reg;
    logic [W-1:0] pend_next;

    // a change in the clearing cycle survives
    always_comb begin
        state_next = i_level;
        pend_next = (i_level ^ state_reg) | (i_clear ? '0 : pend_reg);
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= '0;
            pend_reg <= '0;
        end else begin
            state_reg <= state_next;
            pend_reg <= pend_next;
        end
    end

    assign o_state = state_reg;
    assign o_pending = pend_reg;

endmodule

/* rtl/aesu_pkg.sv */
// audio event status unit: register map, bit positions, reset values, carriers
// assumes one 40 MHz clock; control-port accesses arrive as one-cycle strobes
//
// Notes on behaviour
// (R1) converter clock starvation sets fault bit 3
// (R2) left clipping sets bit 2 until read
// (R3) right clipping sets bit 1 until read
// (R4) mute hint follows fast mode, change-only interrupt
// (R5) host may mute output during fast mode
// (R6) fault enables at bits 2..0, rest reserved
// (R7) any converter interrupt sets summary bit 7
// (R8) host then reads the converter fault register
// (R9) status write during copy sets bit 6
// (R10) transmit user buffer empty sets bit 5
// (R11) status block sent sets bit 4
// (R12) A/B mismatch sets bit 3, never interrupts
// (R13) new receive user block sets bit 2
// (R14) bit 1 on new block or change, by mode
// (R15) any receiver interrupt sets bit 0; host reads errors
// (R16) summary enables per bit, bit 3 reserved
// (R17) sticky receiver errors clear on error read
// (R18) interrupt when any enabled flag is set
// (R19) reserved bits read zero, ignore writes
package aesu_pkg;

    // ------------------------------------------------------------
    // register offsets on the control port
    // ------------------------------------------------------------
    localparam logic [6:0] AESU_OFS_RX_ERR = 7'h18;
    localparam logic [6:0] AESU_OFS_RX_ERR_EN = 7'h19;
    localparam logic [6:0] AESU_OFS_CVT_FLAGS = 7'h1a;
    localparam logic [6:0] AESU_OFS_CVT_EN = 7'h1b;
    localparam logic [6:0] AESU_OFS_SUM = 7'h1c;
    localparam logic [6:0] AESU_OFS_SUM_EN = 7'h1d;

    // ------------------------------------------------------------
    // field positions and implemented-bit masks
    // ------------------------------------------------------------
    localparam int AESU_CVT_SLOW_BIT = 3;
    localparam int AESU_CVT_LEFT_BIT = 2;
    localparam int AESU_CVT_RIGHT_BIT = 1;
    localparam int AESU_CVT_MUTE_BIT = 0;
    localparam int AESU_SUM_CVT_BIT = 7;
    localparam int AESU_SUM_COLL_BIT = 6;
    localparam int AESU_SUM_TXUB_BIT = 5;
    localparam int AESU_SUM_TXCS_BIT = 4;
    localparam int AESU_SUM_DIFF_BIT = 3;
    localparam int AESU_SUM_RXUB_BIT = 2;
    localparam int AESU_SUM_RXCS_BIT = 1;
    localparam int AESU_SUM_RXERR_BIT = 0;
    localparam logic [7:0] AESU_CVT_FLAGS_USED = 8'h0f;
    localparam logic [7:0] AESU_CVT_EN_USED = 8'h07;
    localparam logic [7:0] AESU_SUM_EN_USED = 8'hf7;
    localparam logic [7:0] AESU_RX_ERR_EN_USED = 8'hff;
    // receiver error bits that latch until read; the others track a level
    localparam logic [7:0] AESU_RX_ERR_STICKY = 8'h0a;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] AESU_RST_EN = 8'h00;
    localparam logic [7:0] AESU_RST_FLAGS = 8'h00;
    localparam logic [7:0] AESU_RST_RDATA = 8'h00;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } aesu_reg_req_t;

    typedef struct packed {
        logic too_slow;
        logic left_clip;
        logic right_clip;
        logic fast_mode;
    } aesu_cvt_evt_t;

    typedef struct packed {
        logic tx_cs_write;
        logic tx_cs_copy_busy;
        logic tx_user_empty;
        logic tx_cs_block_done;
        logic rx_ab_mismatch;
        logic rx_user_block;
        logic rx_cs_block_new;
        logic rx_cs_changed;
    } aesu_aud_evt_t;

endpackage

/* rtl/aesu_sticky_bits.sv */
// sticky flag bank: bits set by events, cleared together by one strobe
// assumes set and clear are synchronous one-cycle or level conditions
module aesu_sticky_bits
    import aesu_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic [W-1:0] i_set,
    input wire logic i_clear,
    output logic [W-1:0] o_flags
);

    logic [W-1:0] flags_reg;
    logic [W-1:0] flags_next;

    // an event in the clearing cycle survives
    always_comb begin
        flags_next = i_set | (i_clear ? '0 : flags_reg);
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign o_flags = flags_reg;

endmodule

/* rtl/aesu_top.sv */
// audio event status unit: fault, receiver error and summary flags, enables,
// clear-on-read behaviour and the interrupt output
// assumes the control-port slave hands over one-cycle read and write strobes
module aesu_top
    import aesu_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire aesu_reg_req_t i_reg,
    input wire aesu_cvt_evt_t i_cvt,
    input wire aesu_aud_evt_t i_aud,
    input wire logic [7:0] i_rx_err_cond,
    input wire logic i_rx_status_change_mode,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic o_irq
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic hit(input aesu_reg_req_t req, input logic [6:0] ofs);
        hit = (req.addr == ofs);
    endfunction

    logic rd_cvt;
    logic rd_sum;
    logic rd_rx;

    assign rd_cvt = i_reg.rd && hit(i_reg, AESU_OFS_CVT_FLAGS);
    assign rd_sum = i_reg.rd && hit(i_reg, AESU_OFS_SUM);
    assign rd_rx = i_reg.rd && hit(i_reg, AESU_OFS_RX_ERR);

    // ------------------------------------------------------------
    // converter fault flags
    // ------------------------------------------------------------
    logic [2:0] cvt_sticky;
    logic mute_state;
    logic mute_pend;
    logic [7:0] cvt_flags;
    logic cvt_irq;

    aesu_sticky_bits #(.W(3)) u_cvt_sticky (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_set({i_cvt.too_slow, i_cvt.left_clip, i_cvt.right_clip}), // R1 R2 R3
        .i_clear(rd_cvt),
        .o_flags(cvt_sticky)
    );

    aesu_level_change #(.W(1)) u_cvt_mute (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_level(i_cvt.fast_mode), // R4
        .i_clear(rd_cvt),
        .o_state(mute_state),
        .o_pending(mute_pend)
    );

    assign cvt_flags = {4'h0, cvt_sticky, mute_state} & AESU_CVT_FLAGS_USED; // R19

    // ------------------------------------------------------------
    // receiver error flags
    // ------------------------------------------------------------
    logic [7:0] rx_sticky;
    logic [7:0] rx_state;
    logic [7:0] rx_change;
    logic [7:0] rx_flags;
    logic [7:0] rx_pend;
    logic rx_irq;

    // clear strobe is the error-register read
    aesu_sticky_bits #(.W(8)) u_rx_sticky (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_set(i_rx_err_cond & AESU_RX_ERR_STICKY), // R17
        .i_clear(rd_rx),
        .o_flags(rx_sticky)
    );

    aesu_level_change #(.W(8)) u_rx_level (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_level(i_rx_err_cond & ~AESU_RX_ERR_STICKY),
        .i_clear(rd_rx),
        .o_state(rx_state),
        .o_pending(rx_change)
    );

    assign rx_flags = rx_sticky | rx_state;
    assign rx_pend = rx_sticky | rx_change;

    // ------------------------------------------------------------
    // enable registers
    // ------------------------------------------------------------
    logic [7:0] cvt_en_reg;
    logic [7:0] cvt_en_next;
    logic [7:0] sum_en_reg;
    logic [7:0] sum_en_next;
    logic [7:0] rx_en_reg;
    logic [7:0] rx_en_next;

    always_comb begin
        cvt_en_next = cvt_en_reg;
        sum_en_next = sum_en_reg;
        rx_en_next = rx_en_reg;
        if (i_reg.wr && hit(i_reg, AESU_OFS_CVT_EN)) begin
            cvt_en_next = i_reg.wdata & AESU_CVT_EN_USED; // R6 R19
        end
        if (i_reg.wr && hit(i_reg, AESU_OFS_SUM_EN)) begin
            sum_en_next = i_reg.wdata & AESU_SUM_EN_USED; // R16 R19
        end
        if (i_reg.wr && hit(i_reg, AESU_OFS_RX_ERR_EN)) begin
            rx_en_next = i_reg.wdata & AESU_RX_ERR_EN_USED;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cvt_en_reg <= AESU_RST_EN;
            sum_en_reg <= AESU_RST_EN;
            rx_en_reg <= AESU_RST_EN;
        end else begin
            cvt_en_reg <= cvt_en_next;
            sum_en_reg <= sum_en_next;
            rx_en_reg <= rx_en_next;
        end
    end

    // mute hint interrupts only on a change of state
    assign cvt_irq = (cvt_sticky[1] && cvt_en_reg[AESU_CVT_LEFT_BIT])
        || (cvt_sticky[0] && cvt_en_reg[AESU_CVT_RIGHT_BIT])
        || (mute_pend && cvt_en_reg[AESU_CVT_MUTE_BIT]); // R4 R6
    assign rx_irq = |(rx_pend & rx_en_reg);

    // ------------------------------------------------------------
    // summary status
    // ------------------------------------------------------------
    logic [7:0] sum_set;
    logic [7:0] sum_flags;
    logic rx_cs_event;

    // mode 0: every new block, mode 1: only on change
    assign rx_cs_event = i_rx_status_change_mode ? i_aud.rx_cs_changed : i_aud.rx_cs_block_new; // R14

    always_comb begin
        sum_set = AESU_RST_FLAGS;
        sum_set[AESU_SUM_CVT_BIT] = cvt_irq; // R7
        sum_set[AESU_SUM_COLL_BIT] = i_aud.tx_cs_write && i_aud.tx_cs_copy_busy; // R9
        sum_set[AESU_SUM_TXUB_BIT] = i_aud.tx_user_empty; // R10
        sum_set[AESU_SUM_TXCS_BIT] = i_aud.tx_cs_block_done; // R11
        sum_set[AESU_SUM_DIFF_BIT] = i_aud.rx_ab_mismatch; // R12
        sum_set[AESU_SUM_RXUB_BIT] = i_aud.rx_user_block; // R13
        sum_set[AESU_SUM_RXCS_BIT] = rx_cs_event; // R14
        sum_set[AESU_SUM_RXERR_BIT] = rx_irq; // R15
    end

    aesu_sticky_bits #(.W(8)) u_sum (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_set(sum_set),
        .i_clear(rd_sum),
        .o_flags(sum_flags)
    );

    // ------------------------------------------------------------
    // read port and interrupt output
    // ------------------------------------------------------------
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic irq_reg;
    logic irq_next;

    always_comb begin
        rvalid_next = i_reg.rd;
        rdata_next = AESU_RST_RDATA;
        if (i_reg.rd) begin
            unique case (i_reg.addr)
                AESU_OFS_RX_ERR: rdata_next = rx_flags;
                AESU_OFS_RX_ERR_EN: rdata_next = rx_en_reg;
                AESU_OFS_CVT_FLAGS: rdata_next = cvt_flags; // R19
                AESU_OFS_CVT_EN: rdata_next = cvt_en_reg;
                AESU_OFS_SUM: rdata_next = sum_flags;
                AESU_OFS_SUM_EN: rdata_next = sum_en_reg;
                default: rdata_next = AESU_RST_RDATA;
            endcase
        end
        // mismatch position never reaches the pin
        irq_next = |(sum_flags & sum_en_reg & AESU_SUM_EN_USED); // R12 R16 R18
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_reg <= AESU_RST_RDATA;
            rvalid_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            irq_reg <= irq_next;
        end
    end

    assign o_reg_rdata = rdata_reg;
    assign o_reg_rvalid = rvalid_reg;
    assign o_irq = irq_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    sequence s_enabled_flag;
        |(sum_flags & sum_en_reg & AESU_SUM_EN_USED);
    endsequence

    sequence s_cvt_read_pair;
        rd_cvt ##1 o_reg_rvalid;
    endsequence

    chk_slow_set: assert property (i_cvt.too_slow |=> cvt_flags[AESU_CVT_SLOW_BIT]) // R1
        else $error("starvation flag not set");
    chk_left_hold: assert property (cvt_sticky[1] && !rd_cvt |=> cvt_sticky[1]) // R2
        else $error("left clip flag lost before read");
    chk_right_set: assert property (i_cvt.right_clip |=> cvt_flags[AESU_CVT_RIGHT_BIT]) // R3
        else $error("right clip flag not set");
    chk_mute_quiet: assert property (rd_cvt && (i_cvt.fast_mode == mute_state) |=> !mute_pend) // R4
        else $error("mute hint pending without change");
    chk_mask_block: assert property ((cvt_en_reg == 8'h00) |-> !cvt_irq) // R6
        else $error("masked converter flag interrupts");
    chk_summary_cvt: assert property (cvt_irq |=> sum_flags[AESU_SUM_CVT_BIT]) // R7
        else $error("converter summary not set");
    chk_write_clash: assert property (i_aud.tx_cs_write && i_aud.tx_cs_copy_busy |=> sum_flags[6]) // R9
        else $error("collision flag not set");
    chk_diff_noirq: assert property ((sum_flags == 8'h08) |=> !o_irq) // R12
        else $error("mismatch raised interrupt");
    chk_mode_filter: assert property (i_rx_status_change_mode && !i_aud.rx_cs_changed
        && !sum_flags[1] |=> !sum_flags[1]) // R14
        else $error("status block flag set without change");
    chk_rx_summary: assert property (rx_irq |=> sum_flags[AESU_SUM_RXERR_BIT]) // R15
        else $error("receiver summary not set");
    chk_rx_sticky: assert property (rx_flags[3] && !rd_rx |=> rx_flags[3]) // R17
        else $error("sticky receiver error lost");
    chk_irq_rise: assert property (s_enabled_flag |=> o_irq) // R18
        else $error("interrupt not raised");
    chk_irq_fall: assert property (!(|(sum_flags & sum_en_reg)) |=> !o_irq) // R18
        else $error("interrupt without enabled flag");
    chk_resv_zero: assert property (s_cvt_read_pair |-> o_reg_rdata[7:4] == 4'h0) // R19
        else $error("reserved fault bits not zero");

    // ------------------------------------------------------------
    // multi-step paths and further flag checks
    // ------------------------------------------------------------
    sequence s_left_path;
        i_cvt.left_clip ##1 cvt_en_reg[AESU_CVT_LEFT_BIT] ##1 sum_en_reg[AESU_SUM_CVT_BIT];
    endsequence

    sequence s_rx_sticky_path;
        i_rx_err_cond[3] ##1 rx_en_reg[3];
    endsequence

    // converter flags
    chk_left_irq: assert property (s_left_path |=> o_irq) // R2 R7 R18
        else $error("left clip did not reach the interrupt");
    chk_left_set: assert property (i_cvt.left_clip |=> cvt_flags[AESU_CVT_LEFT_BIT]) // R2
        else $error("left clip flag not set");
    chk_right_hold: assert property (cvt_sticky[0] && !rd_cvt |=> cvt_sticky[0]) // R3
        else $error("right clip flag lost before read");
    chk_slow_noirq: assert property (cvt_sticky[2] && !cvt_sticky[1] && !cvt_sticky[0] && !mute_pend |-> !cvt_irq) // R1
        else $error("starvation flag raised an interrupt");
    chk_mute_level: assert property (1'b1 |=> mute_state == $past(i_cvt.fast_mode)) // R4
        else $error("mute hint does not follow fast mode");
    chk_mute_change: assert property ((i_cvt.fast_mode != mute_state) |=> mute_pend) // R4
        else $error("mute hint change not pending");
    chk_cvt_en_write: assert property (i_reg.wr && (i_reg.addr == AESU_OFS_CVT_EN)
        |=> cvt_en_reg == ($past(i_reg.wdata) & AESU_CVT_EN_USED)) // R6 R19
        else $error("converter enables not written");
    chk_cvt_clear: assert property (rd_cvt && !i_cvt.too_slow && !i_cvt.left_clip && !i_cvt.right_clip
        |=> cvt_sticky == 3'b000) // R2 R3
        else $error("converter flags not cleared by read");

    // summary and receiver
    chk_sum_en_resv: assert property (i_reg.wr && (i_reg.addr == AESU_OFS_SUM_EN) |=> !sum_en_reg[AESU_SUM_DIFF_BIT]) // R16
        else $error("reserved summary enable stored");
    chk_sum_clear: assert property (rd_sum && (sum_set == 8'h00) |=> sum_flags == 8'h00) // R7
        else $error("summary not cleared by read");
    chk_txub_hold: assert property (sum_flags[AESU_SUM_TXUB_BIT] && !rd_sum |=> sum_flags[AESU_SUM_TXUB_BIT]) // R10
        else $error("transmit user flag lost before read");
    chk_txcs_set: assert property (i_aud.tx_cs_block_done |=> sum_flags[AESU_SUM_TXCS_BIT]) // R11
        else $error("status block sent flag not set");
    chk_diff_set: assert property (i_aud.rx_ab_mismatch |=> sum_flags[AESU_SUM_DIFF_BIT]) // R12
        else $error("mismatch flag not set");
    chk_rxub_set: assert property (i_aud.rx_user_block |=> sum_flags[AESU_SUM_RXUB_BIT]) // R13
        else $error("receive user flag not set");
    chk_rxcs_mode0: assert property (!i_rx_status_change_mode && i_aud.rx_cs_block_new
        |=> sum_flags[AESU_SUM_RXCS_BIT]) // R14
        else $error("new status block flag not set");
    chk_rx_path: assert property (s_rx_sticky_path |=> sum_flags[AESU_SUM_RXERR_BIT]) // R15 R17
        else $error("sticky receiver error missed summary");
    chk_rx_level: assert property (((i_rx_err_cond & ~AESU_RX_ERR_STICKY) != rx_state) |=> (rx_change != 8'h00)) // R15
        else $error("receiver level change not pending");
    chk_irq_masked: assert property ((sum_en_reg == 8'h00) |=> !o_irq) // R16 R18
        else $error("interrupt with all enables clear");

endmodule

/* tb/aesu_bench.sv */
// self-checking bench for the audio event status unit
// assumes the host model drives the control port; events driven here
module aesu_bench
    import aesu_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic i_clk_sys;
    logic i_reset_n;
    aesu_reg_req_t reg_req;
    aesu_cvt_evt_t cvt;
    aesu_aud_evt_t aud;
    logic [7:0] rx_err;
    logic mode;
    logic [7:0] rdata;
    logic rvalid;
    logic irq;
    int error_cnt;
    int checks;

    aesu_top DUT (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_reg(reg_req),
        .i_cvt(cvt),
        .i_aud(aud),
        .i_rx_err_cond(rx_err),
        .i_rx_status_change_mode(mode),
        .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid),
        .o_irq(irq)
    );

    aesu_host HOST (
        .i_clk_sys(i_clk_sys),
        .i_rdata(rdata),
        .i_rvalid(rvalid),
        .o_reg(reg_req)
    );

    initial i_clk_sys = 1'b0;
    always #12.5 i_clk_sys = ~i_clk_sys;

    // ----------------------------------------
    // compare and report
    // ----------------------------------------
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bit ok;
        HOST.rd(a, d, ok);
        if (!ok) begin
            error_cnt++;
            $display("unexpected timeout at %0t: got %h expected %h", $time, 1'b0, 1'b1);
            test_done();
        end else begin
            cmp8(d, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // converter or receiver pulse, then flag, summary and irq checks
    task automatic ev_case(input logic [3:0] c, input logic [7:0] r, input logic [6:0] ofs,
                           input logic [7:0] exp, input logic [7:0] sexp, input logic ie);
        @(negedge i_clk_sys);
        cvt = aesu_cvt_evt_t'(c);
        rx_err = r;
        @(negedge i_clk_sys);
        cvt = '0;
        rx_err = 8'h00;
        cycles(4);
        cmp1(irq, ie);
        rd_chk(ofs, exp);
        rd_chk(ofs, 8'h00);
        rd_chk(AESU_OFS_SUM, sexp);
        rd_chk(AESU_OFS_SUM, 8'h00);
        cycles(3);
        cmp1(irq, 1'b0);
    endtask

    task automatic sum_case(input logic [7:0] e, input logic m, input logic [7:0] exp, input logic ie);
        @(negedge i_clk_sys);
        mode = m;
        aud = aesu_aud_evt_t'(e);
        @(negedge i_clk_sys);
        aud = '0;
        cycles(4);
        cmp1(irq, ie);
        rd_chk(AESU_OFS_SUM, exp);
        rd_chk(AESU_OFS_SUM, 8'h00);
        cycles(3);
        cmp1(irq, 1'b0);
    endtask

    initial begin
        i_reset_n = 1'b0;
        cvt = '0;
        aud = '0;
        rx_err = 8'h00;
        mode = 1'b0;
        error_cnt = 0;
        checks = 0;
        repeat (12) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_reset_n = 1'b1;
        cmp1(irq, 1'b0);
        for (int a = 'h18; a <= 'h1d; a++) begin
            rd_chk(7'(a), 8'h00);
        end
        HOST.wr(AESU_OFS_CVT_FLAGS, 8'hff);
        HOST.wr(AESU_OFS_SUM, 8'hff);
        HOST.wr(7'h7f, 8'hff);
        rd_chk(AESU_OFS_CVT_FLAGS, 8'h00);
        rd_chk(AESU_OFS_SUM, 8'h00);
        rd_chk(7'h7f, 8'h00);
        HOST.wr(AESU_OFS_CVT_EN, 8'hff);
        rd_chk(AESU_OFS_CVT_EN, 8'h07);
        HOST.wr(AESU_OFS_SUM_EN, 8'hff);
        rd_chk(AESU_OFS_SUM_EN, 8'hf7);
        HOST.wr(AESU_OFS_RX_ERR_EN, 8'hff);
        rd_chk(AESU_OFS_RX_ERR_EN, 8'hff);
        ev_case(4'h4, 8'h00, AESU_OFS_CVT_FLAGS, 8'h04, 8'h80, 1'b1);
        ev_case(4'h2, 8'h00, AESU_OFS_CVT_FLAGS, 8'h02, 8'h80, 1'b1);
        ev_case(4'h6, 8'h00, AESU_OFS_CVT_FLAGS, 8'h06, 8'h80, 1'b1);
        ev_case(4'h8, 8'h00, AESU_OFS_CVT_FLAGS, 8'h08, 8'h00, 1'b0);
        ev_case(4'h0, 8'h08, AESU_OFS_RX_ERR, 8'h08, 8'h01, 1'b1);
        ev_case(4'h0, 8'h02, AESU_OFS_RX_ERR, 8'h02, 8'h01, 1'b1);
        ev_case(4'h0, 8'h01, AESU_OFS_RX_ERR, 8'h00, 8'h01, 1'b1);
        HOST.wr(AESU_OFS_CVT_EN, 8'h00);
        ev_case(4'h4, 8'h00, AESU_OFS_CVT_FLAGS, 8'h04, 8'h00, 1'b0);
        HOST.wr(AESU_OFS_CVT_EN, 8'h07);
        HOST.wr(AESU_OFS_SUM_EN, 8'h00);
        ev_case(4'h4, 8'h00, AESU_OFS_CVT_FLAGS, 8'h04, 8'h80, 1'b0);
        HOST.wr(AESU_OFS_SUM_EN, 8'hf7);
        // mute hint: level shows, interrupt only on change
        @(negedge i_clk_sys);
        cvt.fast_mode = 1'b1;
        cycles(4);
        cmp1(irq, 1'b1);
        rd_chk(AESU_OFS_CVT_FLAGS, 8'h01);
        rd_chk(AESU_OFS_CVT_FLAGS, 8'h01);
        rd_chk(AESU_OFS_SUM, 8'h80);
        rd_chk(AESU_OFS_SUM, 8'h00);
        cycles(3);
        cmp1(irq, 1'b0);
        cvt.fast_mode = 1'b0;
        cycles(4);
        cmp1(irq, 1'b1);
        rd_chk(AESU_OFS_CVT_FLAGS, 8'h00);
        rd_chk(AESU_OFS_SUM, 8'h80);
        rd_chk(AESU_OFS_SUM, 8'h00);
        sum_case(8'hc0, 1'b0, 8'h40, 1'b1);
        sum_case(8'h80, 1'b0, 8'h00, 1'b0);
        sum_case(8'h20, 1'b0, 8'h20, 1'b1);
        sum_case(8'h10, 1'b0, 8'h10, 1'b1);
        sum_case(8'h08, 1'b0, 8'h08, 1'b0);
        sum_case(8'h04, 1'b0, 8'h04, 1'b1);
        sum_case(8'h02, 1'b0, 8'h02, 1'b1);
        sum_case(8'h01, 1'b0, 8'h00, 1'b0);
        sum_case(8'h01, 1'b1, 8'h02, 1'b1);
        sum_case(8'h02, 1'b1, 8'h00, 1'b0);
        test_done();
    end
endmodule

/* tb/aesu_host.sv */
// host model: control-port reads and writes as one-cycle strobes
// assumes the bench calls its tasks; requests change at the falling edge
module aesu_host
    import aesu_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output aesu_reg_req_t o_reg
);
    timeunit 1ns;
    timeprecision 100ps;

    initial o_reg = '0;

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        o_reg = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge i_clk_sys);
        o_reg = '0;
    endtask

    // one strobe cycle, then a bounded wait for the answer
    task automatic rd(input logic [6:0] a, output logic [7:0] d, output bit ok);
        ok = 1'b0;
        d = 8'h00;
        @(negedge i_clk_sys);
        o_reg = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        for (int n = 0; n < 4 && !ok; n++) begin
            @(negedge i_clk_sys);
            o_reg = '0;
            if (i_rvalid === 1'b1) begin
                ok = 1'b1;
                d = i_rdata;
            end
        end
    endtask
endmodule
